// File: src/dmmd_core.sv
// Operation
// RQ1: port OR reads latch, not pins
// RQ2: F2/F3 writes A at register address
// RQ3: F0 writes A at pointer address
// RQ4: E2/E3 and E0 read into A
// RQ5: byte form puts register on port zero
// RQ6: pointer form: high byte on port two
// RQ7: port two latch unchanged during access
// RQ8: multiply: low A, high B, flags
// RQ9: multiply opcode A4 takes four cycles
// RQ10: code lookup from advanced program counter
// RQ11: sixteen bit add, pointer and flags kept
// RQ12: pointer load: high byte then low byte
// RQ13: bit moves through carry only
// RQ14: E5 loads A from direct address
// RQ15: A from A itself undefined
// RQ16: E6/E7 loads A through bank register
// RQ17: 74 loads A with immediate
// RQ18: F8 to FF stores A in register
// RQ19: strobes only while address valid
// RQ20: register fields use selected bank
`timescale 1ns/100ps
module dmmd_core
  import dmmd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic instr_valid,
  input wire logic [7:0] instr_op,
  input wire logic [7:0] instr_b2,
  input wire logic [7:0] instr_b3,
  input wire logic [15:0] program_counter,
  input wire logic [1:0] bank_sel,
  input wire logic [7:0] bank_register_rd,
  input wire logic [7:0] direct_rd,
  input wire logic direct_bit_rd,
  input wire logic [7:0] code_rd,
  input wire logic [7:0] port_zero_bus_in,
  output logic instr_done,
  output logic [7:0] a_register,
  output logic [7:0] b_register,
  output logic carry_flag,
  output logic product_wide_flag,
  output logic [15:0] data_pointer,
  output logic [4:0] bank_addr,
  output logic bank_we,
  output logic [7:0] bank_wdata,
  output logic [7:0] direct_addr,
  output logic direct_we,
  output logic [7:0] direct_wdata,
  output logic bit_we,
  output logic bit_wdata,
  output logic [15:0] code_addr,
  output logic [7:0] port_two_latch,
  output logic [7:0] port_zero_bus_out,
  output logic port_zero_bus_oe,
  output logic [7:0] port_two_high_addr,
  output logic addr_latch_en,
  output logic ext_rd_n,
  output logic ext_wr_n
);

  // ==========================================================
  // helpers
  function automatic logic [4:0] bank_index(input logic [1:0] bank, input logic [2:0] idx);
    bank_index = {bank, idx}; // [RQ20]
  endfunction : bank_index

  function automatic logic [15:0] code_sum(input logic [7:0] a_val, input logic [15:0] base);
    code_sum = base + {8'h00, a_val}; // [RQ11]
  endfunction : code_sum

  // ==========================================================
  // state
  dmmd_state_t state_reg, state_next;
  logic [2:0] cnt_reg, cnt_next;
  logic [7:0] op_reg, op_next;
  logic [7:0] a_reg, a_next, b_reg, b_next, hi_latch_reg, hi_latch_next;
  logic c_reg, c_next, ov_reg, ov_next;
  logic [15:0] dp_reg, dp_next, xaddr_reg, xaddr_next, caddr_reg, caddr_next;
  logic [7:0] p0o_reg, p0o_next, p2o_reg, p2o_next;
  logic p0oe_reg, p0oe_next, ale_reg, ale_next, rdn_reg, rdn_next, wrn_reg, wrn_next;
  logic done_reg, done_next;
  logic [4:0] baddr_reg, baddr_next;
  logic bwe_reg, bwe_next, dwe_reg, dwe_next, bitwe_reg, bitwe_next, bitd_reg, bitd_next;
  logic [7:0] bwd_reg, bwd_next, daddr_reg, daddr_next, dwd_reg, dwd_next;
  logic [15:0] product;
  logic is_write;

  assign product = {8'h00, a_reg} * {8'h00, b_reg};
  assign is_write = op_reg[4];

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    op_next = op_reg;
    a_next = a_reg;
    b_next = b_reg;
    c_next = c_reg;
    ov_next = ov_reg;
    dp_next = dp_reg;
    hi_latch_next = hi_latch_reg;
    xaddr_next = xaddr_reg;
    caddr_next = caddr_reg;
    p0o_next = p0o_reg;
    p2o_next = p2o_reg;
    p0oe_next = 1'b0;
    ale_next = 1'b0;
    rdn_next = 1'b1;
    wrn_next = 1'b1;
    done_next = 1'b0;
    baddr_next = baddr_reg;
    bwe_next = 1'b0;
    dwe_next = 1'b0;
    bitwe_next = 1'b0;
    bitd_next = bitd_reg;
    bwd_next = bwd_reg;
    daddr_next = daddr_reg;
    dwd_next = dwd_reg;
    unique case (state_reg)
      DMMD_IDLE:
      begin
        if (instr_valid)
        begin
          op_next = instr_op;
          cnt_next = 3'd1;
          if ((instr_op & MASK_IND) == OP_XWR_IND || (instr_op & MASK_IND) == OP_XRD_IND)
          begin
            xaddr_next = {hi_latch_reg, bank_register_rd}; // [RQ5] [RQ20]
            state_next = DMMD_ADDR;
          end
          else if (instr_op == OP_XWR_DP || instr_op == OP_XRD_DP)
          begin
            xaddr_next = dp_reg; // [RQ6]
            state_next = DMMD_ADDR;
          end
          else if (instr_op == OP_MUL)
            state_next = DMMD_MUL; // [RQ9]
          else if (instr_op == OP_CODE_REL)
          begin
            caddr_next = code_sum(a_reg, program_counter + 16'h0001); // [RQ10]
            state_next = DMMD_CODE;
          end
          else if (instr_op == OP_CODE_DP)
          begin
            caddr_next = code_sum(a_reg, dp_reg); // [RQ11]
            state_next = DMMD_CODE;
          end
          else if (instr_op == OP_LD_DP)
          begin
            dp_next = {instr_b2, instr_b3}; // [RQ12]
            state_next = DMMD_WAIT;
          end
          else if (instr_op == OP_C_FROM_BIT)
          begin
            c_next = direct_bit_rd; // [RQ13]
            state_next = DMMD_WAIT;
          end
          else if (instr_op == OP_BIT_FROM_C)
          begin
            bitwe_next = 1'b1; // [RQ13]
            bitd_next = c_reg;
            daddr_next = instr_b2;
            state_next = DMMD_WAIT;
          end
          else if (instr_op == OP_OR_DIR_A || instr_op == OP_OR_DIR_IMM)
          begin
            // direct_rd returns the port latch for port addresses, never pins
            dwe_next = 1'b1;
            daddr_next = instr_b2;
            dwd_next = direct_rd | (instr_op[0] ? instr_b3 : a_reg); // [RQ1]
            if (instr_op[0])
              state_next = DMMD_WAIT;
            else
              done_next = 1'b1;
          end
          else
          begin
            done_next = 1'b1;
            if (instr_op == OP_A_DIRECT)
              a_next = direct_rd; // [RQ14] A-from-A address left undefined [RQ15]
            else if ((instr_op & MASK_IND) == OP_A_IND)
              a_next = direct_rd; // [RQ16]
            else if (instr_op == OP_A_IMM)
              a_next = instr_b2; // [RQ17]
            else if ((instr_op & MASK_BANK) == OP_BANK_A)
            begin
              bwe_next = 1'b1; // [RQ18]
              baddr_next = bank_index(bank_sel, instr_op[2:0]);
              bwd_next = a_reg;
            end
          end
        end
      end
      DMMD_ADDR:
      begin
        p2o_next = xaddr_reg[15:8]; // [RQ6] [RQ7]
        p0o_next = xaddr_reg[7:0]; // [RQ5]
        p0oe_next = 1'b1;
        ale_next = 1'b1;
        state_next = DMMD_DATA;
      end
      DMMD_DATA:
      begin
        if (is_write)
        begin
          p0o_next = a_reg; // [RQ2] [RQ3]
          p0oe_next = 1'b1;
          wrn_next = 1'b0; // [RQ19]
        end
        else
          rdn_next = 1'b0; // [RQ19]
        if (!rdn_reg || !wrn_reg)
        begin
          if (!is_write)
            a_next = port_zero_bus_in; // [RQ4]
          rdn_next = 1'b1;
          wrn_next = 1'b1;
          p0oe_next = 1'b0;
          p2o_next = hi_latch_reg;
          done_next = 1'b1;
          state_next = DMMD_IDLE;
        end
      end
      DMMD_MUL:
      begin
        cnt_next = cnt_reg + 3'd1;
        if (cnt_reg == 3'(MUL_CYCLES - 1))
        begin
          a_next = product[7:0]; // [RQ8]
          b_next = product[15:8];
          ov_next = (product[15:8] != 8'h00);
          c_next = 1'b0;
          done_next = 1'b1;
          state_next = DMMD_IDLE;
        end
      end
      DMMD_CODE:
      begin
        a_next = code_rd; // [RQ10] [RQ11]
        done_next = 1'b1;
        state_next = DMMD_IDLE;
      end
      DMMD_WAIT:
      begin
        done_next = 1'b1;
        state_next = DMMD_IDLE;
      end
      default:
        state_next = DMMD_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= DMMD_IDLE;
      cnt_reg <= 3'd0;
      op_reg <= RST_BYTE;
      a_reg <= RST_BYTE;
      b_reg <= RST_BYTE;
      c_reg <= 1'b0;
      ov_reg <= 1'b0;
      dp_reg <= RST_WORD;
      hi_latch_reg <= RST_PORT;
      xaddr_reg <= RST_WORD;
      caddr_reg <= RST_WORD;
      p0o_reg <= RST_BYTE;
      p2o_reg <= RST_PORT;
      p0oe_reg <= 1'b0;
      ale_reg <= 1'b0;
      rdn_reg <= 1'b1;
      wrn_reg <= 1'b1;
      done_reg <= 1'b0;
      baddr_reg <= 5'd0;
      bwe_reg <= 1'b0;
      dwe_reg <= 1'b0;
      bitwe_reg <= 1'b0;
      bitd_reg <= 1'b0;
      bwd_reg <= RST_BYTE;
      daddr_reg <= RST_BYTE;
      dwd_reg <= RST_BYTE;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      op_reg <= op_next;
      a_reg <= a_next;
      b_reg <= b_next;
      c_reg <= c_next;
      ov_reg <= ov_next;
      dp_reg <= dp_next;
      hi_latch_reg <= hi_latch_next;
      xaddr_reg <= xaddr_next;
      caddr_reg <= caddr_next;
      p0o_reg <= p0o_next;
      p2o_reg <= p2o_next;
      p0oe_reg <= p0oe_next;
      ale_reg <= ale_next;
      rdn_reg <= rdn_next;
      wrn_reg <= wrn_next;
      done_reg <= done_next;
      baddr_reg <= baddr_next;
      bwe_reg <= bwe_next;
      dwe_reg <= dwe_next;
      bitwe_reg <= bitwe_next;
      bitd_reg <= bitd_next;
      bwd_reg <= bwd_next;
      daddr_reg <= daddr_next;
      dwd_reg <= dwd_next;
    end
  end

  assign instr_done = done_reg;
  assign a_register = a_reg;
  assign b_register = b_reg;
  assign carry_flag = c_reg;
  assign product_wide_flag = ov_reg;
  assign data_pointer = dp_reg;
  assign bank_addr = baddr_reg;
  assign bank_we = bwe_reg;
  assign bank_wdata = bwd_reg;
  assign direct_addr = daddr_reg;
  assign direct_we = dwe_reg;
  assign direct_wdata = dwd_reg;
  assign bit_we = bitwe_reg;
  assign bit_wdata = bitd_reg;
  assign code_addr = caddr_reg;
  assign port_two_latch = hi_latch_reg;
  assign port_zero_bus_out = p0o_reg;
  assign port_zero_bus_oe = p0oe_reg;
  assign port_two_high_addr = p2o_reg;
  assign addr_latch_en = ale_reg;
  assign ext_rd_n = rdn_reg;
  assign ext_wr_n = wrn_reg;
endmodule : dmmd_core

// File: src/dmmd_pkg.sv
package dmmd_pkg;

  // ==========================================================
  // opcodes
  localparam logic [7:0] OP_XWR_IND = 8'hF2;
  localparam logic [7:0] OP_XWR_DP = 8'hF0;
  localparam logic [7:0] OP_XRD_IND = 8'hE2;
  localparam logic [7:0] OP_XRD_DP = 8'hE0;
  localparam logic [7:0] OP_MUL = 8'hA4;
  localparam logic [7:0] OP_CODE_REL = 8'h83;
  localparam logic [7:0] OP_CODE_DP = 8'h93;
  localparam logic [7:0] OP_LD_DP = 8'h90;
  localparam logic [7:0] OP_C_FROM_BIT = 8'hA2;
  localparam logic [7:0] OP_BIT_FROM_C = 8'h92;
  localparam logic [7:0] OP_A_DIRECT = 8'hE5;
  localparam logic [7:0] OP_A_IND = 8'hE6;
  localparam logic [7:0] OP_A_IMM = 8'h74;
  localparam logic [7:0] OP_BANK_A = 8'hF8;
  localparam logic [7:0] OP_OR_DIR_A = 8'h42;
  localparam logic [7:0] OP_OR_DIR_IMM = 8'h43;
  localparam logic [7:0] MASK_IND = 8'hFE;
  localparam logic [7:0] MASK_BANK = 8'hF8;
  localparam logic [7:0] ADDR_A_REG = 8'hE0;

  // ==========================================================
  // counts and reset values
  localparam int MUL_CYCLES = 4;
  localparam int TWO_CYCLES = 2;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_PORT = 8'hFF;

  typedef enum logic [2:0] {DMMD_IDLE, DMMD_ADDR, DMMD_DATA, DMMD_MUL, DMMD_CODE, DMMD_WAIT} dmmd_state_t;

endpackage : dmmd_pkg

// File: verification/dmmd_asserts.sv
`timescale 1ns/100ps
// ==========================================================
// port-level checks on the core
module dmmd_asserts
  import dmmd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic instr_valid,
  input wire logic [7:0] instr_op,
  input wire logic [7:0] instr_b2,
  input wire logic [7:0] instr_b3,
  input wire logic [1:0] bank_sel,
  input wire logic [7:0] bank_register_rd,
  input wire logic instr_done,
  input wire logic [7:0] a_register,
  input wire logic [7:0] b_register,
  input wire logic carry_flag,
  input wire logic [15:0] data_pointer,
  input wire logic [4:0] bank_addr,
  input wire logic bank_we,
  input wire logic [7:0] bank_wdata,
  input wire logic [7:0] port_two_latch,
  input wire logic [7:0] port_zero_bus_out,
  input wire logic port_zero_bus_oe,
  input wire logic [7:0] port_two_high_addr,
  input wire logic addr_latch_en,
  input wire logic ext_rd_n,
  input wire logic ext_wr_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  logic busy_reg;
  logic busy_next;
  logic taken;
  // a request is also taken in the cycle that ends the previous one
  assign taken = instr_valid && (!busy_reg || instr_done);
  always_comb
  begin
    busy_next = taken || (busy_reg && !instr_done);
  end
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      busy_reg <= 1'b0;
    else
      busy_reg <= busy_next;
  end
  mul_done_a: assert property (taken && instr_op == OP_MUL |=> !instr_done [*3] ##1 instr_done)
    else $error("multiply did not finish in four cycles");
  mul_result_a: assert property (taken && instr_op == OP_MUL |-> ##4 !carry_flag &&
    {b_register, a_register} == 16'($past(a_register, 4)) * 16'($past(b_register, 4)))
    else $error("multiply product or carry wrong");
  dp_load_a: assert property (taken && instr_op == OP_LD_DP |-> ##2 data_pointer == {$past(instr_b2, 2), $past(instr_b3, 2)})
    else $error("pointer load wrong");
  high_latch_a: assert property ($stable(port_two_latch))
    else $error("high port latch changed");
  rd_strobe_a: assert property ($fell(ext_rd_n) |-> $past(addr_latch_en) ##1 ext_rd_n)
    else $error("read strobe outside address phase");
  wr_data_a: assert property (!ext_wr_n |-> port_zero_bus_oe && port_zero_bus_out == a_register)
    else $error("write strobe without accumulator on bus");
  xdp_addr_a: assert property (taken && (instr_op == OP_XRD_DP || instr_op == OP_XWR_DP) |-> ##2 addr_latch_en &&
    port_zero_bus_out == data_pointer[7:0] && port_two_high_addr == data_pointer[15:8])
    else $error("pointer address not on ports");
  xri_addr_a: assert property (taken && instr_op[7:1] == OP_XRD_IND[7:1] |-> ##2 addr_latch_en &&
    port_zero_bus_out == $past(bank_register_rd, 2))
    else $error("register address not on low port");
  bank_wr_a: assert property (taken && (instr_op & MASK_BANK) == OP_BANK_A |=> bank_we && bank_wdata == a_register &&
    bank_addr == {$past(bank_sel), $past(instr_op[2:0])})
    else $error("bank register store wrong");
endmodule : dmmd_asserts

bind dmmd_core dmmd_asserts dmmd_asserts_inst (.*);

// File: verification/dmmd_xmem_model.sv
`timescale 1ns/100ps
// ==========================================================
// external data memory on the multiplexed low port
module dmmd_xmem_model
(
  input wire logic clk_sys,
  input wire logic addr_latch_en,
  input wire logic [7:0] port_zero_bus_out,
  input wire logic [7:0] port_two_high_addr,
  input wire logic ext_rd_n,
  input wire logic ext_wr_n,
  output logic [7:0] port_zero_bus_in
);
  logic [7:0] mem [0:65535];
  logic [15:0] addr = 16'h0000;
  logic [7:0] last = 8'h00;
  always @(posedge clk_sys)
  begin
    if (addr_latch_en)
      addr <= {port_two_high_addr, port_zero_bus_out};
    if (!ext_wr_n)
      mem[addr] <= port_zero_bus_out;
    if (!ext_rd_n)
      last <= mem[addr];
  end
  // released bus shows the inverse so a stale value cannot pass
  assign port_zero_bus_in = ext_rd_n ? ~last : mem[addr];
endmodule : dmmd_xmem_model

// File: verification/tb_top.sv
`timescale 1ns/100ps
// ==========================================================
// self-checking bench for the decoder core
module tb_top import dmmd_pkg::*;;
  logic clk_sys, rst_b, instr_valid, direct_bit_rd, instr_done, carry_flag, product_wide_flag, bank_we, direct_we;
  logic bit_we, bit_wdata, port_zero_bus_oe, addr_latch_en, ext_rd_n, ext_wr_n;
  logic [7:0] instr_op, instr_b2, instr_b3, bank_register_rd, direct_rd, code_rd, port_zero_bus_in, a_register;
  logic [7:0] b_register, bank_wdata, direct_addr, direct_wdata, port_two_latch, port_zero_bus_out, port_two_high_addr;
  logic [15:0] program_counter, data_pointer, code_addr, bank_q, dir_q, bit_q, pr;
  logic [4:0] bank_addr;
  logic [1:0] bank_sel;
  logic [7:0] v, d, h, l, c, bb;
  int num_errors = 0, checks_done = 0, seed;
  dmmd_core dmmd_core_inst (.*);
  dmmd_xmem_model dmmd_xmem_model_inst (.*);
  initial clk_sys = 1'b0;
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    if (bank_we) bank_q <= {3'b000, bank_addr, bank_wdata};
    if (direct_we) dir_q <= {direct_addr, direct_wdata};
    if (bit_we) bit_q <= {direct_addr, 7'h00, bit_wdata};
  end
  function automatic logic [7:0] r8();
    return 8'($random(seed));
  endfunction : r8
  function automatic logic [15:0] mulx(input logic [7:0] x, input logic [7:0] y);
    return 16'(x) * 16'(y);
  endfunction : mulx
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic run(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] b3);
    int n;
    @(posedge clk_sys) #1;
    {instr_op, instr_b2, instr_b3, instr_valid} = {op, b2, b3, 1'b1};
    @(posedge clk_sys) #1;
    instr_valid = 1'b0;
    n = 0;
    while (instr_done !== 1'b1 && n < 20)
    begin
      @(posedge clk_sys) #1;
      n++;
    end
    if (n == 20) chk("done", 16'h0001, 16'h0000);
    // one more edge so the strobe capture has seen the last pulse
    @(posedge clk_sys) #1;
  endtask : run
  task automatic xfer(input logic [7:0] wr, input logic [7:0] rd, input logic [7:0] val);
    run(OP_A_IMM, val, 8'h00);
    run(wr, 8'h00, 8'h00);
    run(OP_A_IMM, ~val, 8'h00);
    run(rd, 8'h00, 8'h00);
    chk("ext read", {8'h00, val}, {8'h00, a_register});
  endtask : xfer
  task complete_run;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  initial
  begin
    #300000;
    num_errors++;
    complete_run();
  end
  initial
  begin
    seed = 38948;
    {rst_b, instr_valid, direct_bit_rd, bank_sel, bb} = 13'h0000;
    {instr_op, instr_b2, instr_b3, bank_register_rd, direct_rd, code_rd} = 48'h0;
    program_counter = 16'h0000;
    repeat (2) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    chk("idle", 16'h03FF, {6'h00, ext_rd_n, ext_wr_n, port_two_latch});
    for (int i = 0; i < 8; i++)
    begin
      v = (i == 0) ? 8'hFF : r8();
      bank_sel = 2'(i);
      run(OP_A_IMM, v, 8'h00);
      chk("a imm", {8'h00, v}, {8'h00, a_register});
      run(OP_BANK_A | 8'(i), 8'h00, 8'h00);
      chk("bank wr", {3'b000, 2'(i), 3'(i), v}, bank_q);
      direct_rd = r8();
      run(OP_A_DIRECT, 8'h30, 8'h00);
      chk("a direct", {8'h00, direct_rd}, {8'h00, a_register});
      d = r8();
      direct_rd = d;
      run(OP_A_IND | 8'(i % 2), 8'h00, 8'h00);
      chk("a ind", {8'h00, d}, {8'h00, a_register});
      direct_rd = r8();
      run(OP_OR_DIR_A, 8'h90, 8'h00);
      chk("or port", {8'h90, direct_rd | d}, dir_q);
      run(OP_OR_DIR_IMM, 8'hA0, v);
      chk("or imm", {8'hA0, direct_rd | v}, dir_q);
      h = (i == 0) ? 8'hFF : r8();
      l = r8();
      run(OP_LD_DP, h, l);
      chk("pointer", {h, l}, data_pointer);
      xfer(OP_XWR_DP, OP_XRD_DP, r8());
      bank_register_rd = r8();
      d = r8();
      xfer(OP_XWR_IND | 8'(i % 2), OP_XRD_IND | 8'(i % 2), d);
      program_counter = (i == 0) ? 16'h12FE : {r8(), r8()};
      code_rd = r8();
      run(OP_CODE_REL, 8'h00, 8'h00);
      chk("code rel", program_counter + 16'h0001 + 16'(d), code_addr);
      chk("a code", {8'h00, code_rd}, {8'h00, a_register});
      c = code_rd;
      code_rd = r8();
      run(OP_CODE_DP, 8'h00, 8'h00);
      chk("code dp", {h, l} + 16'(c), code_addr);
      chk("dp kept", {h, l}, data_pointer);
      direct_bit_rd = 1'(r8());
      run(OP_C_FROM_BIT, 8'h88, 8'h00);
      chk("carry", {15'h0000, direct_bit_rd}, {15'h0000, carry_flag});
      run(OP_BIT_FROM_C, 8'h97, 8'h00);
      chk("bit wr", {8'h97, 7'h00, direct_bit_rd}, bit_q);
      pr = mulx(code_rd, bb);
      run(OP_MUL, 8'h00, 8'h00);
      chk("product", pr, {b_register, a_register});
      chk("mul flags", {14'h0000, pr > 16'h00FF, 1'b0}, {14'h0000, product_wide_flag, carry_flag});
      bb = pr[15:8];
    end
    complete_run();
  end
endmodule : tb_top
